//--- src/led_output_guard.sv
// Output supervision for a 16-channel PWM sink driver: open-LED detect,
// thermal shutdown, pre-charge gating, auto off and grouped switching.
// Assumes grayscale_clock and blank are synchronous inputs on i_clk.
// Functional notes
// - On 33rd grayscale clock after blank falls, sample lit outputs for open LEDs.
// - Show open-LED status on serial_out while latch_select is low.
// - Hold open-LED results until the 33rd pulse after the next blank fall.
// - Overtemperature switches all outputs off and sets the error flag.
// - Error flag clears when overtemperature indication deasserts.
// - After shutdown, outputs resume on first clock after blank low, flag clear.
// - Pre-charge pull-up turns on after short delay after blank rises.
// - Pre-charge pull-up turns off at once when blank falls.
// - Channels flagged open are forced off.
// - Four groups: 0/4/8/12, 1/5/9/13, 2/6/10/14, 3/7/11/15, in order.
// - Small delay between groups at turn-on; turn-off by blank or overtemp switches all groups at once.
// - All sinks off while blank is high.
// - Status bits copied to top 18 shift bits on first shift after latch falls.
`timescale 1ns/1ps
`include "led_guard_map.svh"
module led_output_guard
    import led_guard_pkg::*;
#(
    parameter int CHANNELS = 16,
    parameter int PRE_CYC = `PRECHG_DELAY_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Controller pins
    input wire logic i_grayscale_clock,
    input wire logic i_output_blank,
    input wire logic i_latch_select,
    input wire logic i_latch_strobe,
    input wire logic i_shift_clock,
    // Grayscale values compared against the counter
    input wire logic [CHANNELS*12-1:0] i_grayscale_value,
    // Analog monitors
    input wire logic [CHANNELS-1:0] i_below_threshold,
    input wire logic i_overtemp,
    input wire logic i_temp_warn,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Outputs
    output logic [CHANNELS-1:0] o_sink_on,
    output logic o_precharge_on,
    output logic o_serial_out,
    output logic o_status_load,
    output logic [`STATUS_BITS-1:0] o_status_info,
    output logic o_overtemp_error_flag,
    output logic o_error_pin_n,
    output logic o_irq
);
    logic gs_d_r, blank_d_r, strobe_d_r, shift_d_r;
    logic [11:0] cnt_r, cnt_nxt;
    logic [CHANNELS-1:0] lod_r, lod_nxt;
    logic [CHANNELS-1:0] pwm_on_r, pwm_on_nxt;
    logic tef_r, tef_nxt, ptw_r;
    thermal_state_t th_r, th_nxt;
    logic [7:0] pre_cnt_r, pre_cnt_nxt;
    logic pre_r, pre_nxt;
    logic load_pend_r, load_pend_nxt;
    logic load_r, load_nxt;
    logic [2:0] sts_r, sts_nxt, mask_r, mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [CHANNELS-1:0] sink_r;
    logic [3:0] grp_req, grp_on;
    logic gs_rise, blank_fall, blank_rise, strobe_fall, shift_rise;
    logic detect_now, run_ok;

    assign gs_rise = i_grayscale_clock && !gs_d_r;
    assign blank_fall = blank_d_r && !i_output_blank;
    assign blank_rise = !blank_d_r && i_output_blank;
    assign strobe_fall = strobe_d_r && !i_latch_strobe;
    assign shift_rise = i_shift_clock && !shift_d_r;
    assign detect_now = gs_rise && (cnt_r == (`DETECT_PULSE - 12'h0001));

    // PWM counter and per-channel on state
    always_comb begin
        cnt_nxt = cnt_r;
        pwm_on_nxt = pwm_on_r;
        if (blank_fall) begin
            cnt_nxt = 12'h0000;
            pwm_on_nxt = '0;
        end else if (gs_rise && !i_output_blank) begin
            if (cnt_r != 12'hFFF) begin
                cnt_nxt = cnt_r + 12'h0001;
            end
            for (int c = 0; c < CHANNELS; c++) begin
                pwm_on_nxt[c] = i_grayscale_value[c*12 +: 12] > cnt_r;
            end
        end
        if (i_output_blank) begin
            pwm_on_nxt = '0;
        end
    end

    // Open-LED latch, updated only at the detection pulse
    always_comb begin
        lod_nxt = lod_r;
        if (detect_now) begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (sink_r[c] || lod_r[c]) begin
                    lod_nxt[c] = sink_r[c] ? i_below_threshold[c] : lod_r[c];
                end
            end
        end
    end

    // Thermal shutdown sequence
    always_comb begin
        th_nxt = th_r;
        tef_nxt = i_overtemp;
        case (th_r)
            TH_RUN: begin
                if (i_overtemp) begin
                    th_nxt = TH_OFF;
                end
            end
            TH_OFF: begin
                // Wait for blank so the restart follows a fresh blank fall
                if (!i_overtemp && i_output_blank) begin
                    th_nxt = TH_WAIT_BLANK;
                end
            end
            TH_WAIT_BLANK: begin
                if (i_overtemp) begin
                    th_nxt = TH_OFF;
                end else if (gs_rise && !i_output_blank) begin
                    th_nxt = TH_RUN;
                end
            end
            default: th_nxt = TH_OFF;
        endcase
    end

    assign run_ok = (th_r == TH_RUN) && !i_overtemp;

    // Group requests: blank and thermal gating, before stagger
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            grp_req[g] = run_ok && !i_output_blank;
        end
    end

    group_stagger u_stagger (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_req(grp_req),
        .o_grp(grp_on)
    );

    // Pre-charge pull-up delay after blank rises
    always_comb begin
        pre_cnt_nxt = pre_cnt_r;
        pre_nxt = pre_r;
        if (!i_output_blank) begin
            pre_nxt = 1'b0;
            pre_cnt_nxt = 8'h00;
        end else if (blank_rise) begin
            pre_cnt_nxt = 8'(PRE_CYC);
        end else if (pre_cnt_r != 8'h00) begin
            pre_cnt_nxt = pre_cnt_r - 8'h01;
            if (pre_cnt_r == 8'h01) begin
                pre_nxt = 1'b1;
            end
        end
    end

    // Status capture into the shift register after the latch strobe
    always_comb begin
        load_pend_nxt = load_pend_r;
        load_nxt = 1'b0;
        if (strobe_fall) begin
            load_pend_nxt = 1'b1;
        end else if (load_pend_r && shift_rise) begin
            load_pend_nxt = 1'b0;
            load_nxt = 1'b1;
        end
    end

    // Sticky events, mask and register reads
    always_comb begin
        sts_nxt = sts_r;
        mask_nxt = mask_r;
        rdata_nxt = 32'h0000_0000;
        if (i_wr && i_addr == 4'h0) begin
            sts_nxt = sts_r & ~i_wdata[2:0];
        end
        if (i_wr && i_addr == 4'h1) begin
            mask_nxt = i_wdata[2:0];
        end
        if (detect_now && |(sink_r & i_below_threshold)) begin
            sts_nxt[`IRQ_LOD_BIT] = 1'b1;
        end
        if (i_overtemp) begin
            sts_nxt[`IRQ_TEF_BIT] = 1'b1;
        end
        if (i_temp_warn) begin
            sts_nxt[`IRQ_PTW_BIT] = 1'b1;
        end
        if (i_rd) begin
            case (i_addr)
                4'h0: rdata_nxt = {29'h0000_0000, sts_r};
                4'h1: rdata_nxt = {29'h0000_0000, mask_r};
                4'h2: rdata_nxt = {14'h0000, lod_r, tef_r, ptw_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gs_d_r <= 1'b0;
            blank_d_r <= 1'b1;
            strobe_d_r <= 1'b0;
            shift_d_r <= 1'b0;
            cnt_r <= 12'h0000;
            pwm_on_r <= '0;
            lod_r <= '0;
            tef_r <= 1'b0;
            ptw_r <= 1'b0;
            th_r <= TH_RUN;
            pre_cnt_r <= 8'h00;
            pre_r <= 1'b0;
            load_pend_r <= 1'b0;
            load_r <= 1'b0;
            sts_r <= 3'h0;
            mask_r <= 3'h0;
            rdata_r <= 32'h0000_0000;
        end else begin
            gs_d_r <= i_grayscale_clock;
            blank_d_r <= i_output_blank;
            strobe_d_r <= i_latch_strobe;
            shift_d_r <= i_shift_clock;
            cnt_r <= cnt_nxt;
            pwm_on_r <= pwm_on_nxt;
            lod_r <= lod_nxt;
            tef_r <= tef_nxt;
            ptw_r <= i_temp_warn;
            th_r <= th_nxt;
            pre_cnt_r <= pre_cnt_nxt;
            pre_r <= pre_nxt;
            load_pend_r <= load_pend_nxt;
            load_r <= load_nxt;
            sts_r <= sts_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Sink outputs: group gate, auto off on detected fault
    // Overtemp bypasses the stagger so shutdown is immediate
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sink_r <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                sink_r[c] <= pwm_on_nxt[c] && grp_on[c % 4] && !lod_nxt[c]
                    && !i_overtemp && !i_output_blank;
            end
        end
    end

    logic serial_out_r, err_n_r, irq_r;
    logic [`STATUS_BITS-1:0] sid_r;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            serial_out_r <= 1'b0;
            err_n_r <= 1'b1;
            irq_r <= 1'b0;
            sid_r <= '0;
        end else begin
            serial_out_r <= !i_latch_select && sid_r[`STATUS_BITS-1];
            err_n_r <= !(tef_nxt || |lod_nxt);
            irq_r <= |(sts_nxt & mask_nxt);
            if (load_nxt) begin
                sid_r <= {lod_r, tef_r, ptw_r};
            end else if (shift_rise) begin
                sid_r <= {sid_r[`STATUS_BITS-2:0], 1'b0};
            end
        end
    end

    assign o_sink_on = sink_r;
    assign o_precharge_on = pre_r;
    assign o_serial_out = serial_out_r;
    assign o_status_load = load_r;
    assign o_status_info = sid_r;
    assign o_overtemp_error_flag = tef_r;
    assign o_error_pin_n = err_n_r;
    assign o_irq = irq_r;
    assign o_rdata = rdata_r;

    sequence blank_low_s;
        !i_output_blank;
    endsequence

    blank_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_output_blank |=> sink_r == '0)
        else $error("sink on while blank high");
    shutdown_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_overtemp |=> sink_r == '0 && tef_r)
        else $error("output on during overtemp");
    flag_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_overtemp |=> !tef_r)
        else $error("error flag stuck");
    pre_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        blank_low_s |=> !pre_r)
        else $error("pre-charge on with blank low");
    pre_delay_a: assert property (@(posedge i_clk) disable iff (i_rst)
        blank_rise |=> !pre_r)
        else $error("pre-charge without delay");
    lod_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !detect_now |=> $stable(lod_r))
        else $error("open-led result changed");
    auto_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 (sink_r & lod_r) == '0)
        else $error("faulty channel driven");
    cnt_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
        blank_fall |=> cnt_r == 12'h0000)
        else $error("counter not restarted");
    serial_out_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_latch_select |=> !serial_out_r)
        else $error("serial out while select high");
    restart_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
        th_r == TH_WAIT_BLANK |=> sink_r == '0)
        else $error("restart before blank");
endmodule

//--- inc/led_guard_map.svh
// Constants for the LED output supervision block.
// Assumes one clock domain at 25 MHz; included by bare name.
`ifndef LED_GUARD_MAP_SVH
`define LED_GUARD_MAP_SVH
`define CLK_PERIOD_NS 40
`define DETECT_PULSE 12'h0021
`define PRECHG_DELAY_NS 80
`define PRECHG_DELAY_CYC ((`PRECHG_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GROUP_DELAY_NS 40
`define GROUP_DELAY_CYC ((`GROUP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STATUS_BITS 18
`define STS_LOD_BIT 2
`define STS_TEF_BIT 1
`define STS_PTW_BIT 0
`define IRQ_LOD_BIT 0
`define IRQ_TEF_BIT 1
`define IRQ_PTW_BIT 2
`endif

//--- inc/led_guard_pkg.sv
// Types for the LED output supervision block.
// Assumes the map header supplies all numbers.
package led_guard_pkg;
    typedef enum logic [1:0] {
        TH_RUN,
        TH_OFF,
        TH_WAIT_BLANK
    } thermal_state_t;
    typedef logic [3:0] group_mask_t;
endpackage

//--- src/group_stagger.sv
// Staggers the four channel groups on and off.
// Assumes a request level from the guard; same clock and reset.
`timescale 1ns/1ps
`include "led_guard_map.svh"
module group_stagger #(
    parameter int GAP_CYC = `GROUP_DELAY_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Requested group enables
    input wire logic [3:0] i_req,
    // Delayed group enables
    output logic [3:0] o_grp
);
    logic [3:0] grp_r, grp_nxt;
    logic [7:0] gap_r, gap_nxt;
    logic moved;

    // Each group follows the previous one after a gap, for both edges
    always_comb begin
        grp_nxt = grp_r;
        gap_nxt = gap_r;
        moved = 1'b0;
        if (gap_r != 8'h00) begin
            gap_nxt = gap_r - 8'h01;
        end else begin
            for (int g = 0; g < 4; g++) begin
                // A gap of one cycle leaves gap_nxt at zero, so track the move
                if (!moved && grp_r[g] != i_req[g]) begin
                    grp_nxt[g] = i_req[g];
                    gap_nxt = 8'(GAP_CYC - 1);
                    moved = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            grp_r <= 4'h0;
            gap_r <= 8'h00;
        end else begin
            grp_r <= grp_nxt;
            gap_r <= gap_nxt;
        end
    end

    assign o_grp = grp_r;

    order_holds_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $countones(grp_r ^ $past(grp_r)) <= 1)
        else $error("two groups switched at once");
endmodule

//--- sim/gs_controller.sv
// Display controller model: drops blank, sends a burst of grayscale clocks,
// then raises blank again. Assumes the guard samples its pins on i_clk.
`timescale 1ns/1ps
module gs_controller (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Burst request and pacing
    input wire logic i_go,
    input wire logic i_slow,
    input wire logic [7:0] i_pulses,
    // Controller pins
    output logic o_grayscale_clock,
    output logic o_output_blank,
    output logic [7:0] o_count
);
    logic [1:0] ph_r;
    logic busy_r;
    // Clock stands low outside a burst; slow mode stretches each half to 3 cycles
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_output_blank <= 1'b1;
            o_grayscale_clock <= 1'b0;
            o_count <= 8'h00;
            ph_r <= 2'h0;
            busy_r <= 1'b0;
        end else if (i_go && !busy_r) begin
            o_output_blank <= 1'b0;
            o_count <= 8'h00;
            ph_r <= 2'h0;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == (i_slow ? 2'h2 : 2'h0)) begin
                ph_r <= 2'h0;
                if (o_grayscale_clock) begin
                    o_grayscale_clock <= 1'b0;
                end else if (o_count == i_pulses) begin
                    o_output_blank <= 1'b1;
                    busy_r <= 1'b0;
                end else begin
                    o_grayscale_clock <= 1'b1;
                    o_count <= o_count + 8'h01;
                end
            end
        end
    end
endmodule

//--- sim/tb_led_output_guard.sv
// Testbench for the LED output guard: controller model, monitors and register port.
// Assumes a 25 MHz clock and sixteen channels.
`timescale 1ns/1ps
`include "led_guard_map.svh"
module tb_led_output_guard;
    logic i_clk, i_rst, go, slow, lsel, lstrobe, shift, overtemp, temp_warn;
    logic reg_wr, reg_rd, gclk, blank, precharge, serial_out, load, overtemp_error_flag, err_n, irq;
    logic [191:0] gs_val;
    logic [15:0] below, sink_on;
    logic [3:0] addr;
    logic [31:0] wdata, rdata;
    logic [`STATUS_BITS-1:0] sts_info;
    logic [7:0] pulses, count;
    int err_count, n_checks, k;
    int on_cyc [16];
    gs_controller u_ctl (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_slow(slow),
        .i_pulses(pulses), .o_grayscale_clock(gclk), .o_output_blank(blank), .o_count(count));
    led_output_guard u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_grayscale_clock(gclk),
        .i_output_blank(blank), .i_latch_select(lsel), .i_latch_strobe(lstrobe),
        .i_shift_clock(shift), .i_grayscale_value(gs_val), .i_below_threshold(below),
        .i_overtemp(overtemp), .i_temp_warn(temp_warn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(reg_wr), .i_rd(reg_rd), .o_rdata(rdata), .o_sink_on(sink_on),
        .o_precharge_on(precharge), .o_serial_out(serial_out), .o_status_load(load),
        .o_status_info(sts_info), .o_overtemp_error_flag(overtemp_error_flag), .o_error_pin_n(err_n),
        .o_irq(irq));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge i_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge i_clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge i_clk);
        reg_rd <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask
    task automatic burst(input logic s, input logic [7:0] n);
        @(posedge i_clk);
        slow <= s;
        pulses <= n;
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        #1;
    endtask
    task automatic wait_count(input logic [7:0] n);
        for (k = 0; k < 400 && count !== n; k++) cycles(1);
        chk(count, n, "pulse count");
    endtask
    task automatic wait_blank;
        for (k = 0; k < 800 && blank !== 1'b1; k++) cycles(1);
        chk(blank, 1'b1, "blank back");
    endtask
    // Generous bound: the whole sequence needs well under 3000 cycles
    initial begin
        #(40 * 30000);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        close_out();
    end
    initial begin
        i_rst = 1'b1;
        {go, slow, lsel, lstrobe, shift} = 5'b00100;
        {overtemp, temp_warn, reg_wr, reg_rd} = 4'h0;
        gs_val = {16{12'h040}};
        below = 16'h0005;
        pulses = 8'h28;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        err_count = 0;
        n_checks = 0;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        cycles(2);
        chk(sink_on, 16'h0000, "sinks blanked");
        foreach (on_cyc[c]) on_cyc[c] = -1;
        burst(1'b0, 8'h28);
        for (int n = 0; n < 12; n++) begin
            cycles(1);
            for (int c = 0; c < 16; c++) if (sink_on[c] === 1'b1 && on_cyc[c] < 0) on_cyc[c] = n;
            if (n == 2) chk(precharge, 1'b0, "pull-up off");
        end
        for (int c = 0; c < 16; c++) chk(on_cyc[c] - on_cyc[c % 4], 0, "group member");
        for (int g = 1; g < 4; g++) chk(on_cyc[g] - on_cyc[g - 1], 1, "group gap");
        wait_blank();
        chk(precharge, 1'b0, "pull-up delayed");
        cycles(5);
        chk(precharge, 1'b1, "pull-up on");
        chk(sink_on, 16'h0000, "sinks blanked");
        reg_read(4'h2, 32'h0000_0014, "first detect");
        chk(err_n, 1'b0, "error pin");
        $display("Test detect and grouping done");
        @(posedge i_clk);
        below <= 16'h0010;
        burst(1'b1, 8'h28);
        cycles(10);
        chk(sink_on, 16'hfffa, "auto off");
        wait_count(8'h20);
        reg_read(4'h2, 32'h0000_0014, "result held");
        wait_count(8'h21);
        reg_read(4'h2, 32'h0000_0054, "second detect");
        chk(sink_on, 16'hffea, "auto off new");
        wait_blank();
        $display("Test hold and auto off done");
        @(posedge i_clk);
        lsel <= 1'b0;
        lstrobe <= 1'b1;
        @(posedge i_clk);
        lstrobe <= 1'b0;
        @(posedge i_clk);
        shift <= 1'b1;
        for (k = 0; k < 6 && load !== 1'b1; k++) cycles(1);
        chk(load, 1'b1, "load pulse");
        cycles(1);
        chk(sts_info, 18'h0_0054, "status load");
        chk(serial_out, 1'b0, "serial msb");
        repeat (11) begin
            @(posedge i_clk);
            shift <= 1'b0;
            @(posedge i_clk);
            shift <= 1'b1;
        end
        cycles(2);
        chk(serial_out, 1'b1, "serial bit");
        @(posedge i_clk);
        lsel <= 1'b1;
        cycles(2);
        chk(serial_out, 1'b0, "serial gated");
        $display("Test serial status done");
        burst(1'b1, 8'h28);
        wait_count(8'h0a);
        @(posedge i_clk);
        overtemp <= 1'b1;
        cycles(3);
        chk(sink_on, 16'h0000, "thermal off");
        chk(overtemp_error_flag, 1'b1, "flag set");
        reg_read(4'h2, 32'h0000_0056, "live flag");
        wait_blank();
        @(posedge i_clk);
        overtemp <= 1'b0;
        cycles(3);
        chk(overtemp_error_flag, 1'b0, "flag clear");
        burst(1'b1, 8'h08);
        for (int n = 0; n < 3; n++) begin
            chk(sink_on, 16'h0000, "restart wait");
            cycles(1);
        end
        wait_count(8'h01);
        cycles(8);
        chk(sink_on, 16'hffea, "restart");
        wait_blank();
        $display("Test thermal done");
        reg_write(4'h1, 32'h0000_0000);
        reg_read(4'h0, 32'h0000_0003, "events");
        reg_write(4'h0, 32'h0000_0007);
        reg_read(4'h0, 32'h0000_0000, "events cleared");
        @(posedge i_clk);
        temp_warn <= 1'b1;
        cycles(2);
        @(posedge i_clk);
        temp_warn <= 1'b0;
        reg_read(4'h0, 32'h0000_0004, "warn event");
        chk(irq, 1'b0, "irq masked");
        reg_write(4'h1, 32'h0000_0004);
        cycles(2);
        chk(irq, 1'b1, "irq raised");
        reg_write(4'h0, 32'h0000_0004);
        cycles(2);
        chk(irq, 1'b0, "irq cleared");
        reg_read(4'h7, 32'h0000_0000, "unmapped");
        reg_write(4'hc, 32'hffff_ffff);
        reg_read(4'h1, 32'h0000_0004, "mask kept");
        $display("Test interrupts done");
        close_out();
    end
endmodule
